// >>> inc/serial_status_map.svh
/*
  Constants of the serial status block: register offsets, field
  positions, reset values and receiver timing.
  Assumes it is included once per compile unit by its bare name.
*/
`ifndef SERIAL_STATUS_MAP_SVH
`define SERIAL_STATUS_MAP_SVH
// ==========================================================
// Register byte offsets.
`define SS_OFF_STATUS 8'h00
`define SS_OFF_DATA 8'h04
`define SS_OFF_CTRL 8'h08
`define SS_OFF_EVENT 8'h0C
`define SS_OFF_MASK 8'h10
// ==========================================================
// Status and event field positions.
`define SS_TXE_BIT 7
`define SS_TXC_BIT 6
`define SS_RXF_BIT 5
`define SS_IDL_BIT 4
`define SS_OVR_BIT 3
`define SS_NSE_BIT 2
`define SS_STP_BIT 1
`define SS_PAR_BIT 0
// ==========================================================
// Control field positions.
`define SS_CTL_TXEN_BIT 4
`define SS_CTL_BRK_BIT 5
// ==========================================================
// Reset values.
`define SS_STATUS_RST 8'hC0
`define SS_CTRL_RST 6'h00
`define SS_MASK_RST 8'h00
// ==========================================================
// Character time in bit times and data bits per frame.
`define SS_CHAR_BITS_8 4'hA
`define SS_CHAR_BITS_9 4'hB
`define SS_DATA_BITS_8 4'h8
`define SS_DATA_BITS_9 4'h9
// Sample phases within one bit of sixteen ticks.
`define SS_PH_E1 4'h3
`define SS_PH_E2 4'h5
`define SS_PH_E3 4'h7
`define SS_PH_A 4'h8
`define SS_PH_B 4'h9
`define SS_PH_C 4'hA
`define SS_PH_END 4'hF
`endif

// >>> inc/serial_status_pkg.sv
/*
  Types of the serial status block.
  Assumes the constants header is compiled alongside.
*/
package serial_status_pkg;
  // ==========================================================
  // Receiver states, Gray coded along the frame.
  typedef enum logic [1:0] {
    RX_WAIT = 2'b00,
    RX_START = 2'b01,
    RX_DATA = 2'b11,
    RX_STOP = 2'b10
  } rx_state_e;
  // ==========================================================
  // A finished receive frame with its error status.
  typedef struct packed {
    logic [8:0] data;
    logic noise;
    logic stop_err;
    logic par_err;
  } rx_frame_s;
  // Control register layout, bit 0 first from the right.
  typedef struct packed {
    logic send_break;
    logic transmitter_enable;
    logic idle_count_type;
    logic nine_bit;
    logic parity_odd;
    logic parity_enable;
  } ctrl_s;
endpackage : serial_status_pkg

// >>> rtl/serial_status_flag_logic.sv
/*
  Status flag logic of an asynchronous serial port, with a small
  oversampling receiver, an APB register slave and one interrupt.
  Assumes RXD and all strobes are synchronous to CLK, RX_TICK pulses
  sixteen times per bit, and the transmit shifter lives outside.
*/
// Chosen here: the register offsets and the APB slave port.
// Functional notes
// - Buffer-empty flag is set at reset and when the shifter takes the buffer.
// - Buffer-empty clears by status read seeing it set, then data write.
// - Complete flag set at reset and when buffer empty, shifter idle and no preamble or break pending.
// - Complete clears after armed status read, then data write, enable rise, break.
// - Receive-full sets when a character moves into the receive data register.
// - Receive-full clears by status read seeing it set, then data read.
// - Idle flag sets after ten or eleven high bit times following activity.
// - With idle type zero, idle counting starts right after the start bit.
// - With idle type one, idle counting starts only after the stop bit.
// - Idle flag sets once, rearmed only by a new received character.
// - Idle flag clears by status read seeing it set, then data read.
// - Overrun sets when a frame ends while unread; new frame is dropped.
// - Overrun clears by status read seeing it set, then data read.
// - Seven start samples and three per bit; disagreement sets the noise flag.
// - Stop-bit error flag sets with receive-full when stop bit reads low.
// - Parity error flag sets with receive-full on a parity mismatch.
// - Noise, stop and parity flags clear by status read, then data read.
// - The status register is read-only; writes to it do nothing.
`timescale 1ns/10ps
`default_nettype none
`include "serial_status_map.svh"
module serial_status_flag_logic (
  input wire logic CLK,
  input wire logic RESETN,
  input wire logic CE,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  output logic IRQ,
  input wire logic RXD,
  input wire logic RX_TICK,
  input wire logic TX_TAKE,
  input wire logic TX_ACTIVE,
  output logic [8:0] TX_DATA,
  output logic TX_BUF_FULL,
  output logic TX_PREAMBLE_REQ,
  output logic TX_BREAK_REQ
);
  // ==========================================================
  // Helpers.
  function automatic logic maj3(input logic a, input logic b,
                                input logic c);
    maj3 = (a & b) | (a & c) | (b & c);
  endfunction : maj3

  function automatic logic split3(input logic a, input logic b,
                                  input logic c);
    split3 = (a != b) | (b != c);
  endfunction : split3

  function automatic logic hit(input logic [7:0] a,
                               input logic [7:0] off);
    hit = (a == off);
  endfunction : hit

  // ==========================================================
  // Declarations.
  logic [7:0] status_reg;
  logic [7:0] status_next;
  logic tx_full_reg;
  logic [7:0] arm_reg;
  logic [7:0] evt_reg;
  logic [7:0] mask_reg;
  logic [7:0] set_v;
  logic [7:0] clr_v;
  serial_status_pkg::ctrl_s ctrl_reg;
  serial_status_pkg::ctrl_s ctrl_wv;
  serial_status_pkg::rx_state_e rx_state_reg;
  serial_status_pkg::rx_frame_s frame;
  logic [31:0] prdata_reg;
  logic [31:0] rd_mux;
  logic pready_reg;
  logic pslverr_reg;
  logic irq_reg;
  logic [8:0] tx_buf_reg;
  logic preamble_reg;
  logic preamble_next;
  logic [8:0] rx_data_reg;
  logic [8:0] shift_reg;
  logic [3:0] phase_reg;
  logic [3:0] bit_cnt_reg;
  logic [1:0] smp_reg;
  logic noise_reg;
  logic [3:0] idle_cnt_reg;
  logic idle_armed_reg;
  logic acc;
  logic wr;
  logic rd;
  logic mapped;
  logic data_wr;
  logic data_rd;
  logic stat_rd;
  logic ctrl_wr;
  logic te_rise;
  logic brk_wr1;
  logic tick;
  logic bit_now;
  logic bit_noise;
  logic decide;
  logic frame_done;
  logic idle_step;
  logic idle_zero;
  logic idle_hit;
  logic [3:0] char_bits;
  logic [3:0] data_bits;
  logic [8:0] aligned;

  assign PRDATA = prdata_reg;
  assign PREADY = pready_reg;
  assign PSLVERR = pslverr_reg;
  assign IRQ = irq_reg;
  assign TX_DATA = tx_buf_reg;
  assign TX_BUF_FULL = tx_full_reg;
  assign TX_PREAMBLE_REQ = preamble_reg;
  assign TX_BREAK_REQ = ctrl_reg.send_break;

  // ==========================================================
  // APB decode. Side effects land on the completing edge only.
  assign acc = PSEL & PENABLE & pready_reg;
  assign wr = acc & PWRITE;
  assign rd = acc & ~PWRITE;
  assign data_wr = wr & hit(PADDR, `SS_OFF_DATA);
  assign data_rd = rd & hit(PADDR, `SS_OFF_DATA);
  assign stat_rd = rd & hit(PADDR, `SS_OFF_STATUS);
  assign ctrl_wr = wr & hit(PADDR, `SS_OFF_CTRL);
  assign ctrl_wv = serial_status_pkg::ctrl_s'(PWDATA[5:0]);
  assign te_rise = ctrl_wr & ctrl_wv.transmitter_enable
                   & ~ctrl_reg.transmitter_enable;
  assign brk_wr1 = ctrl_wr & ctrl_wv.send_break;
  assign mapped = hit(PADDR, `SS_OFF_STATUS) | hit(PADDR, `SS_OFF_DATA)
                  | hit(PADDR, `SS_OFF_CTRL) | hit(PADDR, `SS_OFF_EVENT)
                  | hit(PADDR, `SS_OFF_MASK);

  always_comb begin
    rd_mux = 32'h0000_0000;
    case (PADDR)
      `SS_OFF_STATUS: rd_mux = {24'h00_0000, status_reg};
      `SS_OFF_DATA: rd_mux = {23'h00_0000, rx_data_reg};
      `SS_OFF_CTRL: rd_mux = {26'h000_0000, ctrl_reg};
      `SS_OFF_EVENT: rd_mux = {24'h00_0000, evt_reg};
      `SS_OFF_MASK: rd_mux = {24'h00_0000, mask_reg};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // One wait state: PREADY rises in the second access cycle.
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
    end else if (CE) begin
      if (PSEL & PENABLE & ~pready_reg) begin
        pready_reg <= 1'b1;
        pslverr_reg <= ~mapped;
        prdata_reg <= PWRITE ? 32'h0000_0000 : rd_mux;
      end else begin
        pready_reg <= 1'b0;
        pslverr_reg <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Control, mask and transmit buffer.
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      ctrl_reg <= serial_status_pkg::ctrl_s'(`SS_CTRL_RST);
    end else if (CE && ctrl_wr) begin
      ctrl_reg <= ctrl_wv;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      mask_reg <= `SS_MASK_RST;
    end else if (CE && wr && hit(PADDR, `SS_OFF_MASK)) begin
      mask_reg <= PWDATA[7:0];
    end
  end

  // The buffer is loaded on every data write; it is only handed to
  // the shifter once the empty flag has been properly cleared.
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      tx_buf_reg <= 9'h000;
    end else if (CE && data_wr) begin
      tx_buf_reg <= PWDATA[8:0];
    end
  end

  // The preamble stays requested until the shifter reports activity.
  always_comb begin
    preamble_next = preamble_reg;
    if (TX_ACTIVE) begin
      preamble_next = 1'b0;
    end
    if (te_rise) begin
      preamble_next = 1'b1;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      preamble_reg <= 1'b0;
    end else if (CE) begin
      preamble_reg <= preamble_next;
    end
  end

  // ==========================================================
  // Receiver: sixteen ticks per bit.
  assign tick = RX_TICK;
  assign char_bits = ctrl_reg.nine_bit ? `SS_CHAR_BITS_9
                                       : `SS_CHAR_BITS_8;
  assign data_bits = ctrl_reg.nine_bit ? `SS_DATA_BITS_9
                                       : `SS_DATA_BITS_8;
  assign bit_now = maj3(smp_reg[0], smp_reg[1], RXD);
  assign bit_noise = split3(smp_reg[0], smp_reg[1], RXD);
  assign decide = tick & (phase_reg == `SS_PH_C);
  assign frame_done = decide & (rx_state_reg == serial_status_pkg::RX_STOP);
  assign aligned = ctrl_reg.nine_bit ? shift_reg
                                     : {1'b0, shift_reg[8:1]};

  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      rx_state_reg <= serial_status_pkg::RX_WAIT;
      phase_reg <= 4'h0;
      bit_cnt_reg <= 4'h0;
    end else if (CE && tick) begin
      phase_reg <= phase_reg + 4'h1;
      case (rx_state_reg)
        serial_status_pkg::RX_WAIT: begin
          if (!RXD) begin
            rx_state_reg <= serial_status_pkg::RX_START;
            phase_reg <= 4'h1;
          end
        end
        serial_status_pkg::RX_START: begin
          if (decide && bit_now) begin
            rx_state_reg <= serial_status_pkg::RX_WAIT;
          end else if (phase_reg == `SS_PH_END) begin
            rx_state_reg <= serial_status_pkg::RX_DATA;
            bit_cnt_reg <= 4'h0;
          end
        end
        serial_status_pkg::RX_DATA: begin
          if (phase_reg == `SS_PH_END) begin
            if (bit_cnt_reg == data_bits - 4'h1) begin
              rx_state_reg <= serial_status_pkg::RX_STOP;
            end
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end
        end
        serial_status_pkg::RX_STOP: begin
          if (decide) begin
            rx_state_reg <= serial_status_pkg::RX_WAIT;
          end
        end
        default: rx_state_reg <= serial_status_pkg::RX_WAIT;
      endcase
    end
  end

  // Early start samples only feed the noise verdict, not the bit.
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      smp_reg <= 2'b11;
      noise_reg <= 1'b0;
      shift_reg <= 9'h000;
    end else if (CE && tick) begin
      if (rx_state_reg == serial_status_pkg::RX_WAIT) begin
        noise_reg <= 1'b0;
      end
      if (rx_state_reg == serial_status_pkg::RX_START
          && (phase_reg == `SS_PH_E1 || phase_reg == `SS_PH_E2
              || phase_reg == `SS_PH_E3) && RXD) begin
        noise_reg <= 1'b1;
      end
      if (phase_reg == `SS_PH_A) begin
        smp_reg[0] <= RXD;
      end
      if (phase_reg == `SS_PH_B) begin
        smp_reg[1] <= RXD;
      end
      if (decide && rx_state_reg != serial_status_pkg::RX_WAIT
          && bit_noise) begin
        noise_reg <= 1'b1;
      end
      if (decide && rx_state_reg == serial_status_pkg::RX_DATA) begin
        shift_reg <= {bit_now, shift_reg[8:1]};
      end
    end
  end

  always_comb begin
    frame.data = aligned;
    frame.noise = noise_reg | bit_noise;
    frame.stop_err = ~bit_now;
    frame.par_err = ctrl_reg.parity_enable
                    & ((^aligned) ^ ctrl_reg.parity_odd);
  end

  // A frame ending while the old one is unread is thrown away.
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      rx_data_reg <= 9'h000;
    end else if (CE && frame_done && !status_reg[`SS_RXF_BIT]) begin
      rx_data_reg <= frame.data;
    end
  end

  // ==========================================================
  // Idle line detection.
  always_comb begin
    idle_step = 1'b0;
    idle_zero = 1'b0;
    if (tick) begin
      case (rx_state_reg)
        serial_status_pkg::RX_WAIT: begin
          idle_zero = ~RXD;
          idle_step = RXD & (phase_reg == `SS_PH_END);
        end
        serial_status_pkg::RX_START: idle_zero = 1'b1;
        serial_status_pkg::RX_DATA,
        serial_status_pkg::RX_STOP: begin
          if (ctrl_reg.idle_count_type) begin
            idle_zero = 1'b1;
          end else if (decide) begin
            idle_step = bit_now;
            idle_zero = ~bit_now;
          end
        end
        default: idle_zero = 1'b1;
      endcase
    end
  end

  assign idle_hit = idle_step & idle_armed_reg
                    & (idle_cnt_reg + 4'h1 >= char_bits);

  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      idle_cnt_reg <= 4'h0;
    end else if (CE) begin
      if (idle_zero) begin
        idle_cnt_reg <= 4'h0;
      end else if (idle_step && idle_cnt_reg < char_bits) begin
        idle_cnt_reg <= idle_cnt_reg + 4'h1;
      end
    end
  end

  // A long idle line reports once; a new character rearms it.
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      idle_armed_reg <= 1'b0;
    end else if (CE) begin
      if (set_v[`SS_RXF_BIT]) begin
        idle_armed_reg <= 1'b1;
      end else if (idle_hit) begin
        idle_armed_reg <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Status flags. Set always wins over the access-sequence clear.
  always_comb begin
    set_v = 8'h00;
    clr_v = 8'h00;
    set_v[`SS_TXE_BIT] = TX_TAKE & ~status_reg[`SS_TXE_BIT];
    set_v[`SS_RXF_BIT] = frame_done & ~status_reg[`SS_RXF_BIT];
    set_v[`SS_OVR_BIT] = frame_done & status_reg[`SS_RXF_BIT];
    set_v[`SS_NSE_BIT] = set_v[`SS_RXF_BIT] & frame.noise;
    set_v[`SS_STP_BIT] = set_v[`SS_RXF_BIT] & frame.stop_err;
    set_v[`SS_PAR_BIT] = set_v[`SS_RXF_BIT] & frame.par_err;
    set_v[`SS_IDL_BIT] = idle_hit;
    clr_v[`SS_TXE_BIT] = data_wr & arm_reg[`SS_TXE_BIT];
    clr_v[`SS_TXC_BIT] = arm_reg[`SS_TXC_BIT]
                         & (data_wr | te_rise | brk_wr1);
    clr_v[5:0] = {6{data_rd}} & arm_reg[5:0];
    status_next = (status_reg & ~clr_v) | set_v;
    // Judged on the state after this edge so that queuing work clears it.
    set_v[`SS_TXC_BIT] = status_next[`SS_TXE_BIT] & ~TX_ACTIVE
                         & ~preamble_next
                         & ~(brk_wr1 | (ctrl_reg.send_break & ~ctrl_wr));
    status_next[`SS_TXC_BIT] = status_next[`SS_TXC_BIT]
                               | set_v[`SS_TXC_BIT];
  end

  // Writes to the status offset reach nothing here.
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      status_reg <= `SS_STATUS_RST;
      tx_full_reg <= 1'b0;
    end else if (CE) begin
      status_reg <= status_next;
      tx_full_reg <= ~status_next[`SS_TXE_BIT];
    end
  end

  // Arming uses the value software actually got back on PRDATA.
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      arm_reg <= 8'h00;
    end else if (CE) begin
      if (stat_rd) begin
        arm_reg <= prdata_reg[7:0];
      end else begin
        if (data_wr) begin
          arm_reg[`SS_TXE_BIT] <= 1'b0;
        end
        if (data_wr || te_rise || brk_wr1) begin
          arm_reg[`SS_TXC_BIT] <= 1'b0;
        end
        if (data_rd) begin
          arm_reg[5:0] <= 6'h00;
        end
      end
    end
  end

  // ==========================================================
  // Interrupt events: sticky, write one to clear, set wins.
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      evt_reg <= 8'h00;
    end else if (CE) begin
      if (wr && hit(PADDR, `SS_OFF_EVENT)) begin
        evt_reg <= (evt_reg & ~PWDATA[7:0]) | (set_v & ~status_reg);
      end else begin
        evt_reg <= evt_reg | (set_v & ~status_reg);
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      irq_reg <= 1'b0;
    end else if (CE) begin
      irq_reg <= |(evt_reg & mask_reg);
    end
  end
endmodule : serial_status_flag_logic
`default_nettype wire

// >>> test/serial_node.sv
/*
  Remote serial node: sends frames on the receive line and stands in
  for the transmit shifter.
  Assumes the bench calls send; a tick every two clocks.
*/
`timescale 1ns/10ps
`default_nettype none
module serial_node (
  input wire logic clk,
  input wire logic resetn,
  input wire logic tx_buf_full,
  input wire logic tx_preamble_req,
  input wire logic tx_break_req,
  output logic rx_tick,
  output logic rxd,
  output logic tx_take,
  output logic tx_active
);
  logic [5:0] busy_reg;
  initial begin
    rx_tick = 1'b0;
    rxd = 1'b1;
    tx_take = 1'b0;
    busy_reg = 6'h00;
  end
  always @(posedge clk) begin
    rx_tick <= !rx_tick;
  end
  // ==========================================================
  // Shifter: forty clocks a character, far short of a real frame,
  // so that the bench stays brief.
  always @(posedge clk) begin
    tx_take <= 1'b0;
    if (!resetn) begin
      busy_reg <= 6'h00;
    end else if (busy_reg == 6'h00 && (tx_buf_full || tx_preamble_req)) begin
      tx_take <= tx_buf_full;
      busy_reg <= 6'h28;
    end else if (busy_reg != 6'h00) begin
      busy_reg <= busy_reg - 6'h01;
    end
  end
  assign tx_active = busy_reg != 6'h00 || tx_break_req;
  // ==========================================================
  // Frame sender, start bit first; the line idles high afterwards.
  task automatic send(input logic [9:0] bits, input int glitch);
    int b;
    int p;
    for (b = 0; b < 10; b++) begin
      for (p = 0; p < 16; p++) begin
        @(posedge clk iff rx_tick);
        rxd <= (b == glitch && p == 8) ? !bits[b] : bits[b];
      end
    end
    @(posedge clk iff rx_tick);
    rxd <= 1'b1;
  endtask : send
endmodule : serial_node
`default_nettype wire

// >>> test/serial_status_flag_logic_monitor.sv
/*
  Port checks of the serial status block, bound to its top module.
  Assumes one clock; checks pause while reset is low or CE is low.
*/
`timescale 1ns/10ps
`default_nettype none
`include "serial_status_map.svh"
module serial_status_flag_logic_monitor (
  input wire logic CLK,
  input wire logic RESETN,
  input wire logic CE,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic IRQ,
  input wire logic RXD,
  input wire logic RX_TICK,
  input wire logic TX_TAKE,
  input wire logic TX_ACTIVE,
  input wire logic [8:0] TX_DATA,
  input wire logic TX_BUF_FULL,
  input wire logic TX_PREAMBLE_REQ,
  input wire logic TX_BREAK_REQ
);
  logic done;
  logic data_wr;
  logic ctrl_wr;
  assign done = PSEL && PENABLE && PREADY;
  assign data_wr = done && PWRITE && PADDR == `SS_OFF_DATA;
  assign ctrl_wr = done && PWRITE && PADDR == `SS_OFF_CTRL;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESETN || !CE);
  // ==========================================================
  // Bus handshake.
  sequence s_setup;
    PSEL && !PENABLE;
  endsequence
  sequence s_access;
    PSEL && PENABLE && !PREADY;
  endsequence
  property p_one_wait;
    s_setup ##1 s_access |=> PREADY;
  endproperty
  a_one_wait: assert property (p_one_wait) else $error("ready late");
  property p_ready_pulse;
    PREADY |=> !PREADY;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("ready held");
  property p_unmapped;
    PREADY && PADDR > `SS_OFF_MASK |-> PSLVERR && (PWRITE || PRDATA == 32'h0);
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped not refused");
  property p_mapped;
    PREADY && PADDR <= `SS_OFF_MASK && PADDR[1:0] == 2'h0 |-> !PSLVERR;
  endproperty
  a_mapped: assert property (p_mapped) else $error("mapped refused");
  // ==========================================================
  // Transmit buffer flags, data and requests.
  property p_status_read;
    PREADY && !PWRITE && PADDR == `SS_OFF_STATUS
      |-> PRDATA[`SS_TXE_BIT] == !$past(TX_BUF_FULL) && PRDATA[31:8] == 24'h0;
  endproperty
  a_status_read: assert property (p_status_read) else $error("status read");
  property p_take;
    TX_TAKE && TX_BUF_FULL |=> !TX_BUF_FULL;
  endproperty
  a_take: assert property (p_take) else $error("take kept full");
  property p_hold_full;
    TX_BUF_FULL && !TX_TAKE |=> TX_BUF_FULL;
  endproperty
  a_hold_full: assert property (p_hold_full) else $error("full dropped");
  property p_full_cause;
    !TX_BUF_FULL ##1 TX_BUF_FULL |-> $past(data_wr);
  endproperty
  a_full_cause: assert property (p_full_cause) else $error("full no write");
  property p_tx_load;
    data_wr |=> TX_DATA == $past(PWDATA[8:0]);
  endproperty
  a_tx_load: assert property (p_tx_load) else $error("tx data not loaded");
  property p_break;
    ctrl_wr |=> TX_BREAK_REQ == $past(PWDATA[`SS_CTL_BRK_BIT]);
  endproperty
  a_break: assert property (p_break) else $error("break request");
  property p_preamble_drop;
    TX_PREAMBLE_REQ && TX_ACTIVE && !ctrl_wr |=> !TX_PREAMBLE_REQ;
  endproperty
  a_preamble_drop: assert property (p_preamble_drop) else $error("preamble held");
endmodule : serial_status_flag_logic_monitor
bind serial_status_flag_logic serial_status_flag_logic_monitor mon_u (
  .CLK(CLK), .RESETN(RESETN), .CE(CE), .PSEL(PSEL), .PENABLE(PENABLE),
  .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
  .PREADY(PREADY), .PSLVERR(PSLVERR), .IRQ(IRQ), .RXD(RXD), .RX_TICK(RX_TICK),
  .TX_TAKE(TX_TAKE), .TX_ACTIVE(TX_ACTIVE), .TX_DATA(TX_DATA),
  .TX_BUF_FULL(TX_BUF_FULL), .TX_PREAMBLE_REQ(TX_PREAMBLE_REQ),
  .TX_BREAK_REQ(TX_BREAK_REQ)
);
`default_nettype wire

// >>> test/tb.sv
/*
  Bench of the serial status block: APB master, note queue and watcher.
  Assumes the node model on the line side.
*/
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, irq, rxd, rx_tick, tx_take, tx_active;
  logic tx_buf_full, tx_pre, tx_brk, ce = 1'b1;
  logic [8:0] tx_data;
  logic [64:0] note;
  logic [64:0] notes[$];
  logic [31:0] seed = 32'h7D6B;
  logic [7:0] ed[3] = '{8'h35, 8'h35, 8'hB5};
  logic es[3] = '{1'b1, 1'b0, 1'b1};
  int eg[3] = '{3, 99, 99};
  logic [31:0] ef[3] = '{32'h24, 32'h22, 32'h21};
  int fail_count = 0;
  int n_tests = 0;
  int k;
  always #4 clk = ~clk;
  serial_status_flag_logic dut_u (
    .CLK(clk), .RESETN(resetn), .CE(ce), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .IRQ(irq), .RXD(rxd), .RX_TICK(rx_tick), .TX_TAKE(tx_take),
    .TX_ACTIVE(tx_active), .TX_DATA(tx_data), .TX_BUF_FULL(tx_buf_full),
    .TX_PREAMBLE_REQ(tx_pre), .TX_BREAK_REQ(tx_brk)
  );
  serial_node peer_u (
    .clk(clk), .resetn(resetn), .tx_buf_full(tx_buf_full), .tx_preamble_req(tx_pre),
    .tx_break_req(tx_brk), .rx_tick(rx_tick), .rxd(rxd), .tx_take(tx_take),
    .tx_active(tx_active)
  );
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : xs
  task automatic summarize();
    if (fail_count == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : summarize
  task automatic check(input string what, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", what, e, g);
    end
  endtask : check
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [31:0] e, input logic [31:0] m, input logic err);
    int i = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    notes.push_back({err, m, e});
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      i++;
    end while (pready !== 1'b1 && i < 20);
    if (pready !== 1'b1) begin
      fail_count++;
      summarize();
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    apb(1'b0, a, 32'h0, e, m, 1'b0);
  endtask : rd
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 32'h0, 32'h0, 1'b0);
  endtask : wr
  task automatic chars(input int n);
    repeat (n * 32) @(posedge clk);
  endtask : chars
  // ==========================================================
  // Watcher: each completed transfer is judged against the oldest note.
  always @(posedge clk) begin
    if (psel && penable && pready === 1'b1) begin
      note = notes.pop_front();
      check("pslverr", {31'h0, note[64]}, {31'h0, pslverr});
      check("prdata", note[31:0], prdata & note[63:32]);
    end
  end
  initial begin
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    seed = xs(seed);
    wr(8'h04, seed);
    @(negedge clk);
    check("tx_data", {23'h0, seed[8:0]}, {23'h0, tx_data});
    check("tx_buf_full", 32'h0, {31'h0, tx_buf_full});
    rd(8'h00, 32'hC0, 32'hFFFFFFFF);
    rd(8'h08, 32'h0, 32'hFFFFFFFF);
    rd(8'h10, 32'h0, 32'hFFFFFFFF);
    apb(1'b0, 8'h14, 32'h0, 32'h0, 32'hFFFFFFFF, 1'b1);
    wr(8'h00, 32'hFF);
    rd(8'h00, 32'hC0, 32'hFF);
    wr(8'h04, 32'h1A5);
    rd(8'h00, 32'h80, 32'hC0);
    wr(8'h04, 32'h05A);
    rd(8'h00, 32'h00, 32'hC0);
    repeat (100) @(posedge clk);
    rd(8'h00, 32'hC0, 32'hC0);
    wr(8'h08, 32'h10);
    rd(8'h00, 32'h80, 32'hC0);
    repeat (60) @(posedge clk);
    rd(8'h00, 32'hC0, 32'hC0);
    wr(8'h08, 32'h30);
    repeat (60) @(posedge clk);
    rd(8'h00, 32'h80, 32'hC0);
    wr(8'h08, 32'h10);
    repeat (60) @(posedge clk);
    rd(8'h00, 32'hC0, 32'hFF);
    wr(8'h0C, 32'hFF);
    wr(8'h10, 32'h20);
    @(negedge clk);
    check("irq", 32'h0, {31'h0, irq});
    seed = xs(seed);
    peer_u.send({1'b1, seed[7:0], 1'b0}, 99);
    rd(8'h04, {24'h0, seed[7:0]}, 32'h1FF);
    @(negedge clk);
    check("irq", 32'h1, {31'h0, irq});
    rd(8'h0C, 32'h20, 32'h20);
    chars(14);
    rd(8'h00, 32'hF0, 32'hFF);
    rd(8'h04, {24'h0, seed[7:0]}, 32'h1FF);
    rd(8'h00, 32'hC0, 32'hFF);
    wr(8'h0C, 32'h20);
    repeat (2) @(negedge clk);
    check("irq", 32'h0, {31'h0, irq});
    chars(24);
    rd(8'h00, 32'hC0, 32'hFF);
    for (k = 0; k < 2; k++) begin
      wr(8'h08, (k == 1) ? 32'h18 : 32'h10);
      peer_u.send({1'b1, 8'hFF, 1'b0}, 99);
      chars(3);
      rd(8'h00, (k == 1) ? 32'h20 : 32'h30, 32'h30);
      chars(12);
      rd(8'h00, 32'h30, 32'h30);
      rd(8'h04, 32'hFF, 32'h1FF);
    end
    wr(8'h08, 32'h11);
    for (k = 0; k < 3; k++) begin
      peer_u.send({es[k], ed[k], 1'b0}, eg[k]);
      chars(2);
      rd(8'h00, ef[k], 32'h2F);
      rd(8'h04, {24'h0, ed[k]}, 32'h1FF);
      rd(8'h00, 32'h0, 32'h2F);
    end
    peer_u.send({1'b1, 8'h11, 1'b0}, 99);
    peer_u.send({1'b1, 8'h22, 1'b0}, 99);
    rd(8'h00, 32'h28, 32'h2F);
    rd(8'h04, 32'h11, 32'h1FF);
    ce <= 1'b0;
    peer_u.send(10'h266, 99);
    ce <= 1'b1;
    rd(8'h00, 32'h0, 32'h2F);
    summarize();
  end
endmodule : tb
`default_nettype wire
